/* File: cid_fsk_defines.vh */
// Constants for the caller ID FSK sequencer
`ifndef CID_FSK_DEFINES_VH
`define CID_FSK_DEFINES_VH

// Command byte layout
`define CID_CMD_WRITE_BIT 7
`define CID_CMD_ADDR_MSB 6

// Register addresses (7-bit part of the command byte)
`define CID_ADDR_FLAG 7'h32
`define CID_ADDR_DATA 7'h33
`define CID_ADDR_SEIZE 7'h34
`define CID_ADDR_MARK 7'h35
`define CID_ADDR_CTRL 7'h36

// Control register field positions
`define CID_CTRL_TS 0
`define CID_CTRL_MAS 1
`define CID_CTRL_BS 2
`define CID_CTRL_EN 3
`define CID_CTRL_CS_LSB 4
`define CID_CTRL_CS_MSB 5

// Reset values
`define CID_RST_LEN 8'h00
`define CID_RST_CS 2'h0
`define CID_RST_BIT 1'h0

// Data byte limit and message memory
`define CID_MAX_BYTES 7'h40
`define CID_RAM_DEPTH 64
`define CID_BITS_PER_BYTE 4'h8

// Bit timing: 25 MHz system clock over 1200 baud
`define CID_BIT_CYCLES 15'h5161

`endif

/* File: cid_fsk_sequencer.v */
// Caller ID FSK bit sequencer with command-byte register access
//
// Operation
// R01 - Flag run of ones between message bytes
// R02 - Send programmed number of message bytes
// R03 - Data counts above 64 send 64
// R04 - Seizure sends twice-value alternating zero-one bits
// R05 - Initial mark sends programmed run of ones
// R06 - Two-bit field picks one of four channels
// R07 - Control register read 36H, write B6H
// R08 - Command bit 7 selects read or write
// R09 - Seizure, mark, data; self-clear start; trailing mark
`timescale 1ns/1ps
`default_nettype none
`include "cid_fsk_defines.vh"

module cid_fsk_sequencer #(
    parameter [14:0] BIT_CYCLES = `CID_BIT_CYCLES
) (
    input wire clk,
    input wire rstn,
    input wire cmdStrobe,
    input wire [7:0] cmdByte,
    input wire [7:0] cmdWrData,
    input wire ramWrEn,
    input wire [5:0] ramAddr,
    input wire [7:0] ramWrData,
    output wire [7:0] rdData,
    output wire rdValid,
    output wire fskBit,
    output wire fskActive,
    output wire [3:0] fskLine,
    output wire fskStandard
);

    ////////////////////////////////////////////////////////////////////////
    // Phase codes
    localparam [2:0] PH_IDLE = 3'h0;
    localparam [2:0] PH_SEIZE = 3'h1;
    localparam [2:0] PH_MARK = 3'h2;
    localparam [2:0] PH_DATA = 3'h3;
    localparam [2:0] PH_FLAG = 3'h4;
    localparam [2:0] PH_TRAIL = 3'h5;
    localparam [2:0] PH_END = 3'h6;

    // Register file
    reg [7:0] flagLen_r; // Flag bit count
    reg [7:0] dataLen_r; // Message byte count
    reg [7:0] seizeLen_r; // Seizure half count
    reg [7:0] markLen_r; // Mark bit count
    reg [1:0] chanSel_r; // Channel select
    reg genEnable_r; // Generator enable
    reg stdSel_r; // Modulation standard
    reg trailMark_r; // Trailing mark enable
    reg txStart_r; // Transmit start

    // Message memory
    reg [7:0] msgRam [0:`CID_RAM_DEPTH-1];

    // Sequencer state
    reg [2:0] phase_r;
    reg [8:0] bitCnt_r; // Bits left in phase
    reg [6:0] byteIdx_r; // Current message byte
    reg [2:0] bitIdx_r; // Bit within byte
    reg [14:0] divCnt_r; // Bit-time divider
    reg fskBit_r;
    reg fskActive_r;
    reg [3:0] fskLine_r;
    reg [7:0] rdData_r;
    reg rdValid_r;

    // Command decode
    wire cmdWrite = cmdStrobe & cmdByte[`CID_CMD_WRITE_BIT]; // R08
    wire cmdRead = cmdStrobe & ~cmdByte[`CID_CMD_WRITE_BIT]; // R08
    wire [6:0] cmdAddr = cmdByte[`CID_CMD_ADDR_MSB:0];
    wire bitTick = (divCnt_r == BIT_CYCLES - 15'h1);
    wire [7:0] ctrlValue = {2'h0, chanSel_r, genEnable_r, stdSel_r,
                            trailMark_r, txStart_r};
    // Clamped byte count
    wire [6:0] effLen = (dataLen_r > {1'b0, `CID_MAX_BYTES}) ?
                        `CID_MAX_BYTES : dataLen_r[6:0]; // R03
    wire lastByte = (byteIdx_r + 7'h1 == effLen);
    wire startReq = genEnable_r & txStart_r & (phase_r == PH_IDLE);
    // Last bit has stood a full bit time, or nothing was sent
    wire endDone = (phase_r == PH_END) & (bitTick | ~fskActive_r);
    wire [3:0] chanHot = 4'h1 << chanSel_r; // One-hot channel select
    ////////////////////////////////////////////////////////////////////////
    // Phase following a given one, skipping empty phases
    function [2:0] nextPhase;
        input [2:0] cur;
        begin
            if ((cur == PH_IDLE) && (seizeLen_r != `CID_RST_LEN))
                nextPhase = PH_SEIZE; // R04
            else if ((cur != PH_MARK) && (markLen_r != `CID_RST_LEN))
                nextPhase = PH_MARK; // R05
            else if (effLen != 7'h0)
                nextPhase = PH_DATA; // R02
            else
                nextPhase = PH_END; // R09
        end
    endfunction
    // Bit count loaded on entry to a phase
    function [8:0] phaseLen;
        input [2:0] ph;
        begin
            case (ph)
                PH_SEIZE: phaseLen = {seizeLen_r, 1'b0}; // R04
                PH_MARK: phaseLen = {1'b0, markLen_r}; // R05
                PH_FLAG: phaseLen = {1'b0, flagLen_r}; // R01
                default: phaseLen = {5'h0, `CID_BITS_PER_BYTE};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Message memory write port
    always @(posedge clk) begin
        if (ramWrEn) begin
            msgRam[ramAddr] <= ramWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and read answers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flagLen_r <= `CID_RST_LEN;
            dataLen_r <= `CID_RST_LEN;
            seizeLen_r <= `CID_RST_LEN;
            markLen_r <= `CID_RST_LEN;
            chanSel_r <= `CID_RST_CS;
            genEnable_r <= `CID_RST_BIT;
            stdSel_r <= `CID_RST_BIT;
            trailMark_r <= `CID_RST_BIT;
            txStart_r <= `CID_RST_BIT;
            rdData_r <= `CID_RST_LEN;
            rdValid_r <= `CID_RST_BIT;
        end else begin
            rdValid_r <= cmdRead;
            // Hardware clear of start: end of data or disable
            if (endDone || !genEnable_r) begin
                txStart_r <= 1'b0; // R09
            end
            if (cmdWrite) begin
                case (cmdAddr)
                    `CID_ADDR_FLAG: flagLen_r <= cmdWrData; // R01
                    `CID_ADDR_DATA: dataLen_r <= cmdWrData; // R02
                    `CID_ADDR_SEIZE: seizeLen_r <= cmdWrData; // R04
                    `CID_ADDR_MARK: markLen_r <= cmdWrData; // R05
                    `CID_ADDR_CTRL: begin
                        // Host write wins over the hardware clear
                        chanSel_r <= cmdWrData[`CID_CTRL_CS_MSB:
                                               `CID_CTRL_CS_LSB]; // R06
                        genEnable_r <= cmdWrData[`CID_CTRL_EN]; // R07
                        stdSel_r <= cmdWrData[`CID_CTRL_BS];
                        trailMark_r <= cmdWrData[`CID_CTRL_MAS];
                        txStart_r <= cmdWrData[`CID_CTRL_TS];
                    end
                    default: ; // Unmapped write ignored
                endcase
            end
            if (cmdRead) begin
                case (cmdAddr)
                    `CID_ADDR_FLAG: rdData_r <= flagLen_r;
                    `CID_ADDR_DATA: rdData_r <= dataLen_r;
                    `CID_ADDR_SEIZE: rdData_r <= seizeLen_r;
                    `CID_ADDR_MARK: rdData_r <= markLen_r;
                    `CID_ADDR_CTRL: rdData_r <= ctrlValue; // R07
                    default: rdData_r <= 8'h00; // Unmapped reads zero
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit-time divider, restarted when a transmission begins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_r <= 15'h0;
        end else if (startReq || bitTick) begin
            divCnt_r <= 15'h0;
        end else begin
            divCnt_r <= divCnt_r + 15'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer: one bit per tick
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= PH_IDLE;
            bitCnt_r <= 9'h0;
            byteIdx_r <= 7'h0;
            bitIdx_r <= 3'h0;
            fskBit_r <= 1'b1;
            fskActive_r <= 1'b0;
        end else if (!genEnable_r) begin
            // Disable aborts and mutes
            phase_r <= PH_IDLE;
            fskActive_r <= 1'b0;
            fskBit_r <= 1'b1;
        end else begin
            case (phase_r)
                PH_IDLE: begin
                    if (startReq) begin
                        phase_r <= nextPhase(PH_IDLE); // R09
                        bitCnt_r <= phaseLen(nextPhase(PH_IDLE));
                        byteIdx_r <= 7'h0;
                        bitIdx_r <= 3'h0;
                    end
                end
                PH_SEIZE, PH_MARK: begin
                    if (bitTick) begin
                        fskActive_r <= 1'b1;
                        // Seizure starts with zero, then alternates
                        fskBit_r <= (phase_r == PH_SEIZE) ?
                                    bitCnt_r[0] : 1'b1; // R04 R05
                        if (bitCnt_r == 9'h1) begin
                            phase_r <= nextPhase(phase_r);
                            bitCnt_r <= phaseLen(nextPhase(phase_r));
                        end else begin
                            bitCnt_r <= bitCnt_r - 9'h1;
                        end
                    end
                end
                PH_DATA: begin
                    if (bitTick) begin
                        fskActive_r <= 1'b1;
                        fskBit_r <= msgRam[byteIdx_r[5:0]][bitIdx_r];
                        bitIdx_r <= bitIdx_r + 3'h1;
                        if (bitIdx_r == 3'h7) begin
                            if (lastByte) begin
                                phase_r <= PH_END; // R02
                            end else if (flagLen_r != `CID_RST_LEN) begin
                                phase_r <= PH_FLAG; // R01
                                bitCnt_r <= phaseLen(PH_FLAG);
                            end else begin
                                byteIdx_r <= byteIdx_r + 7'h1;
                            end
                        end
                    end
                end
                PH_FLAG: begin
                    if (bitTick) begin
                        fskBit_r <= 1'b1; // R01
                        if (bitCnt_r == 9'h1) begin
                            phase_r <= PH_DATA;
                            byteIdx_r <= byteIdx_r + 7'h1;
                        end else begin
                            bitCnt_r <= bitCnt_r - 9'h1;
                        end
                    end
                end
                PH_END: begin
                    // Last bit keeps its full bit time; start clears here
                    if (endDone) begin
                        phase_r <= trailMark_r ? PH_TRAIL : PH_IDLE; // R09
                        fskActive_r <= fskActive_r & trailMark_r;
                        fskBit_r <= 1'b1;
                    end
                end
                PH_TRAIL: begin
                    if (!trailMark_r) begin
                        phase_r <= PH_IDLE;
                        fskActive_r <= 1'b0;
                    end else if (bitTick) begin
                        fskBit_r <= 1'b1; // R09
                    end
                end
                default: phase_r <= PH_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel line outputs, only the selected one carries data
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : gLine
            always @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    fskLine_r[ch] <= 1'b1;
                end else begin
                    fskLine_r[ch] <= (fskActive_r && chanHot[ch]) ?
                                     fskBit_r : 1'b1; // R06
                end
            end
        end
    endgenerate
    // Outputs straight from flops
    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign fskBit = fskBit_r;
    assign fskActive = fskActive_r;
    assign fskLine = fskLine_r;
    assign fskStandard = stdSel_r;
endmodule // cid_fsk_sequencer
`default_nettype wire

/* File: cid_fsk_monitor.sv */
// Port checker for the caller ID FSK sequencer
`timescale 1ns/1ps
`default_nettype none
module cid_fsk_monitor #(
    parameter [14:0] BIT_CYCLES = 15'h0004
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmdStrobe,
    input wire logic [7:0] cmdByte,
    input wire logic [7:0] cmdWrData,
    input wire logic ramWrEn,
    input wire logic [5:0] ramAddr,
    input wire logic [7:0] ramWrData,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic fskBit,
    input wire logic fskActive,
    input wire logic [3:0] fskLine,
    input wire logic fskStandard
);
    logic [1:0] chSel; // Shadow of the channel field
    logic prevBit; // Line bit one edge back
    logic prevActive; // Active flag one edge back
    logic [15:0] bitAge; // Edges the line bit has held
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Shadow channel writes and age the bit
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chSel <= 2'h0;
            prevBit <= 1'b1;
            prevActive <= 1'b0;
            bitAge <= 16'h0000;
        end else begin
            if (cmdStrobe && cmdByte == 8'hb6) chSel <= cmdWrData[5:4];
            prevBit <= fskBit;
            prevActive <= fskActive;
            bitAge <= (fskBit != prevBit || !prevActive) ? 16'h0000 :
                bitAge + 16'h0001;
        end
    end
    rd_answer_a: assert property (cmdStrobe && !cmdByte[7] |=> rdValid)
        else $error("read got no answer");
    rd_cause_a: assert property (rdValid |-> $past(cmdStrobe && !cmdByte[7]))
        else $error("answer without read");
    rd_hold_a: assert property (!rdValid |-> $stable(rdData))
        else $error("read data moved");
    idle_lines_a: assert property (!$past(fskActive) |-> fskLine == 4'hf)
        else $error("line not idle");
    other_lines_a: assert property (
        (fskLine | (4'h1 << $past(chSel))) == 4'hf)
        else $error("wrong channel driven");
    line_follow_a: assert property ($past(fskActive) |->
        fskLine[$past(chSel)] == $past(fskBit))
        else $error("line bit wrong");
    idle_bit_a: assert property (!fskActive |-> fskBit)
        else $error("idle bit not one");
    bit_time_a: assert property (fskActive && prevActive &&
        fskBit != prevBit |-> bitAge % BIT_CYCLES == BIT_CYCLES - 1)
        else $error("bit time wrong");
    cover property (fskActive && !fskBit);
    cover property (rdValid);
    cover property ($fell(fskActive));
endmodule // cid_fsk_monitor
bind cid_fsk_sequencer cid_fsk_monitor #(.BIT_CYCLES(BIT_CYCLES)) mon_i (
    .clk(clk), .rstn(rstn), .cmdStrobe(cmdStrobe), .cmdByte(cmdByte),
    .cmdWrData(cmdWrData), .ramWrEn(ramWrEn), .ramAddr(ramAddr),
    .ramWrData(ramWrData), .rdData(rdData), .rdValid(rdValid),
    .fskBit(fskBit), .fskActive(fskActive), .fskLine(fskLine),
    .fskStandard(fskStandard));
`default_nettype wire

/* File: cid_line_model.sv */
// Line terminal model sampling the selected channel mid-bit
`timescale 1ns/1ps
`default_nettype none
module cid_line_model #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fskActive,
    input wire logic [3:0] fskLine,
    input wire logic [1:0] chSel,
    output logic bitV,
    output logic bitVal
);
    logic [15:0] cnt; // Edges since the line went active
    // Take one bit per bit time from the chosen line
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 16'h0000;
            bitV <= 1'b0;
            bitVal <= 1'b1;
        end else begin
            cnt <= fskActive ? cnt + 16'h0001 : 16'h0000;
            bitV <= fskActive && (cnt % BIT_CYCLES == 2);
            bitVal <= fskLine[chSel];
        end
    end
endmodule // cid_line_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the caller ID FSK sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int B = 4; // Shortened bit time
    logic clk, rstn, cmdStrobe, ramWrEn;
    logic [7:0] cmdByte, cmdWrData, ramWrData, a;
    logic [7:0] msg [64];
    logic [5:0] ramAddr;
    logic [1:0] ch;
    logic [15:0] lfsr;
    wire [7:0] rdData;
    wire rdValid, fskBit, fskActive, fskStandard, bitV, bitVal;
    wire [3:0] fskLine;
    logic [7:0] rdQ [$];
    logic bitQ [$];
    int bad_count, n_checks, cyc, bitMode, i;
    cid_fsk_sequencer #(.BIT_CYCLES(15'h0004)) cid_fsk_sequencer_i (
        .clk(clk), .rstn(rstn), .cmdStrobe(cmdStrobe), .cmdByte(cmdByte),
        .cmdWrData(cmdWrData), .ramWrEn(ramWrEn), .ramAddr(ramAddr),
        .ramWrData(ramWrData), .rdData(rdData), .rdValid(rdValid),
        .fskBit(fskBit), .fskActive(fskActive), .fskLine(fskLine),
        .fskStandard(fskStandard));
    cid_line_model #(.BIT_CYCLES(B)) cid_line_model_i (.clk(clk),
        .rstn(rstn), .fskActive(fskActive), .fskLine(fskLine),
        .chSel(ch), .bitV(bitV), .bitVal(bitVal));
    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmd(logic [7:0] b, logic [7:0] d);
        @(posedge clk);
        #1 cmdStrobe = 1'b1;
        cmdByte = b;
        cmdWrData = d;
        @(posedge clk);
        #1 cmdStrobe = 1'b0;
    endtask
    task automatic rd(logic [6:0] ad, logic [7:0] e);
        rdQ.push_back(e);
        cmd({1'b0, ad}, 8'h00);
    endtask
    task automatic run_seq(logic [7:0] sl, ml, dl, fl, logic [1:0] c,
        logic mas, abort);
        logic [7:0] ctl;
        int k;
        cmd(8'hb4, sl);
        cmd(8'hb5, ml);
        cmd(8'hb3, dl);
        cmd(8'hb2, fl);
        lfsr = nx(lfsr);
        ctl = {2'b00, c, 1'b1, lfsr[0], mas, 1'b1};
        bitMode = abort ? 2 : mas ? 1 : 0;
        for (k = 0; k < 2 * sl; k++) bitQ.push_back(k[0]);
        for (k = 0; k < ml; k++) bitQ.push_back(1'b1);
        for (k = 0; k < 8 * ((dl > 64) ? 64 : dl); k++) begin
            if (k > 0 && k % 8 == 0) repeat (fl) bitQ.push_back(1'b1);
            bitQ.push_back(msg[k / 8][k % 8]);
        end
        ch = c;
        cmd(8'hb6, ctl);
        if (abort) begin
            repeat (50) @(posedge clk);
            ctl = ctl & 8'h34;
            cmd(8'hb6, ctl);
            bitQ.delete();
        end
        for (k = 0; k < 3000 && bitQ.size() > 0; k++) @(posedge clk);
        if (mas) begin
            repeat (4 * B) @(posedge clk);
            chk("fskActive", {7'h00, fskActive}, 8'h01);
            ctl = ctl & 8'hfc;
            cmd(8'hb6, ctl);
        end
        for (k = 0; k < 100 && fskActive !== 1'b0; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        bitMode = 0;
        chk("fskActive", {7'h00, fskActive}, 8'h00);
        chk("bits left", 8'(bitQ.size()), 8'h00);
        chk("fskStandard", {7'h00, fskStandard}, {7'h00, ctl[2]});
        rd(7'h36, ctl & 8'hfe);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    // Compare results against the oldest notes
    always @(posedge clk) begin
        #2;
        if (rdValid === 1'b1)
            chk("rdData", rdData, rdQ.size() ? rdQ.pop_front() : 8'hxx);
        if (bitV === 1'b1 && !(bitMode == 2 || (bitMode == 1 &&
            bitQ.size() == 0 && bitVal)))
            chk("line bit", {7'h00, bitVal},
                bitQ.size() ? {7'h00, bitQ.pop_front()} : 8'hxx);
    end
    initial begin
        rstn = 1'b0;
        {cmdStrobe, ramWrEn, cmdByte, cmdWrData, ramAddr, ramWrData} = '0;
        ch = 2'h0;
        lfsr = 16'h2deb;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        for (a = 8'h32; a <= 8'h37; a++) rd(a[6:0], 8'h00);
        cmd(8'hb7, 8'hff);
        rd(7'h37, 8'h00);
        for (a = 8'h32; a < 8'h36; a++) begin
            lfsr = nx(lfsr);
            cmd({1'b1, a[6:0]}, lfsr[7:0]);
            rd(a[6:0], lfsr[7:0]);
        end
        cmd(8'hb6, 8'hfe);
        rd(7'h36, 8'h3e);
        cmd(8'hb6, 8'h00);
        for (i = 0; i < 64; i++) begin
            lfsr = nx(lfsr);
            msg[i] = lfsr[7:0];
            @(posedge clk);
            #1 ramWrEn = 1'b1;
            ramAddr = i[5:0];
            ramWrData = msg[i];
        end
        @(posedge clk);
        #1 ramWrEn = 1'b0;
        run_seq(8'h02, 8'h03, 8'h02, 8'h02, 2'h0, 1'b0, 1'b0);
        run_seq(8'h00, 8'h00, 8'h03, 8'h00, 2'h1, 1'b0, 1'b0);
        run_seq(8'h00, 8'h00, 8'hff, 8'h01, 2'h2, 1'b0, 1'b0);
        run_seq(8'h00, 8'h00, 8'h00, 8'h00, 2'h3, 1'b0, 1'b0);
        run_seq(8'h01, 8'h01, 8'h01, 8'h00, 2'h3, 1'b1, 1'b0);
        run_seq(8'hff, 8'h00, 8'h00, 8'h00, 2'h1, 1'b0, 1'b1);
        test_done();
    end
endmodule // tb
`default_nettype wire
